// ==== core/srap_consts.svh ====
`ifndef SRAP_CONSTS_SVH
`define SRAP_CONSTS_SVH

// ****************************************
// Register select codes
// ****************************************
`define SRAP_SEL_CMD       2'h0
`define SRAP_SEL_SETUP     2'h1
`define SRAP_SEL_TEST      2'h2
`define SRAP_SEL_RESULT    2'h3

// ****************************************
// Register sizes in serial bits
// ****************************************
`define SRAP_LEN_BYTE      5'h08
`define SRAP_LEN_WORD      5'h10

// ****************************************
// Reset values
// ****************************************
`define SRAP_SETUP_RST     8'h28
`define SRAP_TEST_RST      8'h00

// ****************************************
// Timing counts
// ****************************************
`define SRAP_CLK_PERIOD_NS 10
`define SRAP_RESYNC_ONES   6'h20
`define SRAP_GUARD_CYC     500
`define SRAP_UPDATE_CYC    20000

`endif

// ==== core/srap_pkg.sv ====
`default_nettype none

// ****************************************
// Types shared by the serial register port
// ****************************************
package srap_pkg;

  // Command register layout, most significant field first
  typedef struct packed {
    logic       write_gate_ready_bit; // Gate on write, ready flag on read
    logic       zero_bit;             // Always zero
    logic [1:0] target_sel;           // target_select_hi, target_select_lo
    logic       read_dir;             // 1 read, 0 write
    logic       power_down_bit;       // Standby request
    logic [1:0] gain_code;            // gain_code_hi, gain_code_lo
  } srap_cmd_t;

  // Synchronised serial pin events
  typedef struct packed {
    logic rise; // Serial clock rising edge seen
    logic fall; // Serial clock falling edge seen
    logic din;  // Synchronised data level
  } srap_pins_t;

  // Serial interface states
  typedef enum logic [1:0] {
    ST_CMD,
    ST_WRITE,
    ST_READ
  } srap_state_t;

endpackage

`default_nettype wire

// ==== core/srap_pin_sync.sv ====
`default_nettype none

// ****************************************
// Two-stage pin synchroniser and edge finder
// ****************************************
module srap_pin_sync (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Raw pins
  input  wire logic               sclk_i,
  input  wire logic               din_i,
  // Synchronised events
  output var srap_pkg::srap_pins_t  pins_o
);

  logic [1:0] meta_q;  // First stage, read only by the second
  logic [1:0] sync_q;  // Second stage: {sclk, din}
  logic       prev_q;  // Last synchronised clock level

  // Double-flop both pins; idle levels are high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
      prev_q <= 1'b1;
    end else begin
      meta_q <= {sclk_i, din_i};
      sync_q <= meta_q;
      prev_q <= sync_q[1];
    end
  end

  // Edge events, registered so they line up with data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_o <= '0;
    end else begin
      pins_o.rise <= sync_q[1] & ~prev_q;
      pins_o.fall <= ~sync_q[1] & prev_q;
      pins_o.din  <= sync_q[0];
    end
  end

endmodule

`default_nettype wire

// ==== core/srap_serial_regs.sv ====
// Behaviour
// - Four registers, reached only by serial port
// - Start with command write; reset waits command
// - After one access, return to command wait
// - Thirty-two ones on data input resynchronise
// - Command register eight bits, fixed field order
// - Hold first bit until zero, load seven
// - Command read top bit equals ready pin
// - Second command bit written zero, reads zero
// - Select code picks register and its size
// - Direction bit: zero write, one read
// - Standby bit powers down, resets to zero
// - Gain code selects 1, 2, 32, 128
// - Setup register read/write, resets to 28h
// - Ready low on update, high after result read
`include "srap_consts.svh"
`default_nettype none

module srap_serial_regs #(
  parameter int unsigned UPDATE_CYCLES = `SRAP_UPDATE_CYC // Master cycles per result
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Serial pins
  input  wire logic        sclk_i,
  input  wire logic        din_i,
  output logic             dout_o,
  output logic             result_ready_n_o,
  // Converter side
  input  wire logic [15:0] result_word_i,
  output logic             power_down_o,
  output logic [1:0]       gain_code_o,
  output logic [7:0]       setup_o,
  output logic [7:0]       test_o
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam int TW = $clog2(UPDATE_CYCLES + 1);

  srap_pkg::srap_pins_t  pins;        // Synchronised pin events
  srap_pkg::srap_state_t state_q;     // Interface state
  srap_pkg::srap_cmd_t   cmd_q;       // Command register
  srap_pkg::srap_cmd_t   cmd_in;      // Command being completed
  logic [4:0]            bit_q;       // Bit position in current access
  logic [4:0]            len_q;       // Length of selected register
  logic [5:0]            ones_q;      // Consecutive ones on data input
  logic [15:0]           sh_q;        // Shared shift register
  logic [15:0]           wr_word;     // Word as completed by this edge
  logic [15:0]           rd_word;     // Left-justified read value
  logic [7:0]            setup_q;     // Setup register
  logic [7:0]            test_q;      // Factory test register
  logic [15:0]           result_q;    // Result register
  logic                  ready_n_q;   // Result ready, active low
  logic                  dout_q;      // Serial output bit
  logic [TW-1:0]         timer_q;     // Update period counter
  logic                  resync;      // Thirty-second one this edge
  logic                  cmd_done;    // Command load this edge
  logic                  acc_done;    // Last bit of an access this edge
  logic                  upd_now;     // Result update this cycle
  logic                  guard_now;   // Guard window starts next cycle

  // Register size from select code
  function automatic logic [4:0] target_len(input logic [1:0] sel);
    target_len = (sel == `SRAP_SEL_RESULT) ? `SRAP_LEN_WORD : `SRAP_LEN_BYTE;
  endfunction

  // ****************************************
  // Pin synchroniser
  // ****************************************
  srap_pin_sync u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .sclk_i (sclk_i),
    .din_i  (din_i),
    .pins_o (pins)
  );

  // ****************************************
  // Edge decode
  // ****************************************
  // Data is taken on each rising serial clock, most significant first
  assign wr_word  = {sh_q[14:0], pins.din};
  assign cmd_in   = wr_word[7:0];
  assign resync   = pins.rise & pins.din & (ones_q == `SRAP_RESYNC_ONES - 6'h01);
  assign cmd_done = pins.rise & ~resync & (state_q == srap_pkg::ST_CMD)
                    & (bit_q == 5'h07);
  assign acc_done = pins.rise & ~resync & (state_q != srap_pkg::ST_CMD)
                    & (bit_q == len_q - 5'h01);
  assign upd_now  = ~cmd_q.power_down_bit & (timer_q == TW'(UPDATE_CYCLES - 1));
  assign guard_now = ~cmd_q.power_down_bit
                     & (timer_q == TW'(UPDATE_CYCLES - 1 - `SRAP_GUARD_CYC));

  // Read value for the register being selected, left justified
  always_comb begin
    case (cmd_in.target_sel)
      // Command read returns the command being loaded at this edge
      `SRAP_SEL_CMD:   rd_word = {ready_n_q, 1'b0, cmd_in[5:0], 8'h00};
      `SRAP_SEL_SETUP: rd_word = {setup_q, 8'h00};
      `SRAP_SEL_TEST:  rd_word = {test_q, 8'h00};
      default:         rd_word = result_q;
    endcase
  end

  // ****************************************
  // Interface state machine
  // ****************************************
  // Reset and resync both land in command wait at the gate bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= srap_pkg::ST_CMD;
      bit_q   <= 5'h00;
      len_q   <= `SRAP_LEN_BYTE;
    end else if (resync) begin
      state_q <= srap_pkg::ST_CMD;
      bit_q   <= 5'h00;
    end else if (pins.rise) begin
      case (state_q)
        srap_pkg::ST_CMD: begin
          if (bit_q == 5'h00 && pins.din) begin
            bit_q <= 5'h00;
          end else if (cmd_done) begin
            bit_q   <= 5'h00;
            len_q   <= target_len(cmd_in.target_sel);
            state_q <= cmd_in.read_dir ? srap_pkg::ST_READ : srap_pkg::ST_WRITE;
          end else begin
            bit_q <= bit_q + 5'h01;
          end
        end
        srap_pkg::ST_WRITE,
        srap_pkg::ST_READ: begin
          if (acc_done) begin
            state_q <= srap_pkg::ST_CMD;
            bit_q   <= 5'h00;
          end else begin
            bit_q <= bit_q + 5'h01;
          end
        end
        default: begin
          state_q <= srap_pkg::ST_CMD;
          bit_q   <= 5'h00;
        end
      endcase
    end
  end

  // Run of ones on the data input, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ones_q <= 6'h00;
    end else if (pins.rise) begin
      if (!pins.din) begin
        ones_q <= 6'h00;
      end else if (ones_q != `SRAP_RESYNC_ONES) begin
        ones_q <= ones_q + 6'h01;
      end
    end
  end

  // ****************************************
  // Shift path
  // ****************************************
  // Shift in on rising edges; a read loads the selected value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_q <= 16'h0000;
    end else if (cmd_done && cmd_in.read_dir) begin
      sh_q <= rd_word;
    end else if (pins.rise) begin
      sh_q <= wr_word;
    end
  end

  // Output bit: first bit at load, then one per falling edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dout_q <= 1'b1;
    end else if (cmd_done && cmd_in.read_dir) begin
      dout_q <= rd_word[15];
    end else if (pins.fall) begin
      dout_q <= (state_q == srap_pkg::ST_READ) ? sh_q[15] : 1'b1;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  // Command register; gate and zero bits are never stored as one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_q <= '0;
    end else if (cmd_done) begin
      cmd_q          <= cmd_in;
      cmd_q.zero_bit <= 1'b0;
    end else if (acc_done && state_q == srap_pkg::ST_WRITE
                 && cmd_q.target_sel == `SRAP_SEL_CMD) begin
      cmd_q.power_down_bit <= wr_word[2];
      cmd_q.gain_code      <= wr_word[1:0];
    end
  end

  // Setup and test registers take a completed write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      setup_q <= `SRAP_SETUP_RST;
      test_q  <= `SRAP_TEST_RST;
    end else if (acc_done && state_q == srap_pkg::ST_WRITE) begin
      if (cmd_q.target_sel == `SRAP_SEL_SETUP) begin
        setup_q <= wr_word[7:0];
      end
      if (cmd_q.target_sel == `SRAP_SEL_TEST) begin
        test_q <= wr_word[7:0];
      end
    end
  end

  // ****************************************
  // Result update and ready flag
  // ****************************************
  // Update period; paused in standby
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_q <= '0;
    end else if (upd_now) begin
      timer_q <= '0;
    end else if (!cmd_q.power_down_bit) begin
      timer_q <= timer_q + TW'(1);
    end
  end

  // Result capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_q <= 16'h0000;
    end else if (upd_now) begin
      result_q <= result_word_i;
    end
  end

  // Ready flag: an update wins over a finishing read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_n_q <= 1'b1;
    end else if (upd_now) begin
      ready_n_q <= 1'b0;
    end else if (guard_now) begin
      ready_n_q <= 1'b1;
    end else if (acc_done && state_q == srap_pkg::ST_READ
                 && cmd_q.target_sel == `SRAP_SEL_RESULT) begin
      ready_n_q <= 1'b1;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign dout_o           = dout_q;
  assign result_ready_n_o = ready_n_q;
  assign power_down_o     = cmd_q.power_down_bit;
  assign gain_code_o      = cmd_q.gain_code;
  assign setup_o          = setup_q;
  assign test_o           = test_q;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_cmd_done;
    cmd_done;
  endsequence

  sequence s_read_entry;
    cmd_done ##0 cmd_in.read_dir;
  endsequence

  AST_SETUP_RESET: assert property (@(posedge clk_i)
    $fell(rst_i) |-> setup_q == `SRAP_SETUP_RST && !power_down_o)
    else $error("setup or standby wrong after reset");

  AST_GATE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    pins.rise && !resync && state_q == srap_pkg::ST_CMD && bit_q == 5'h00 && pins.din
    |=> state_q == srap_pkg::ST_CMD && bit_q == 5'h00)
    else $error("gate bit of one advanced the command");

  AST_RESYNC: assert property (@(posedge clk_i) disable iff (rst_i)
    pins.rise && pins.din && ones_q == 6'h1F |=> state_q == srap_pkg::ST_CMD && bit_q == 5'h00)
    else $error("32 ones did not resynchronise");

  AST_RETURN: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_done |=> state_q == srap_pkg::ST_CMD && bit_q == 5'h00)
    else $error("access did not return to command wait");

  AST_CMD_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    s_cmd_done |=> cmd_q[5:0] == $past(wr_word[5:0]) && !cmd_q.zero_bit)
    else $error("command fields not loaded");

  AST_DIRECTION: assert property (@(posedge clk_i) disable iff (rst_i)
    s_cmd_done |=> state_q == ($past(wr_word[3]) ? srap_pkg::ST_READ : srap_pkg::ST_WRITE))
    else $error("direction bit not followed");

  AST_LENGTH: assert property (@(posedge clk_i) disable iff (rst_i)
    s_cmd_done |=> len_q == (($past(wr_word[5:4]) == 2'h3) ? 5'h10 : 5'h08))
    else $error("register length wrong");

  AST_CMD_READ: assert property (@(posedge clk_i) disable iff (rst_i)
    s_read_entry ##0 (cmd_in.target_sel == `SRAP_SEL_CMD)
    |=> sh_q[15] == $past(ready_n_q) && sh_q[14] == 1'b0 && dout_q == $past(ready_n_q)
        && sh_q[13:8] == $past(wr_word[5:0]))
    else $error("command read top bits wrong");

  AST_READY_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
    upd_now |=> !result_ready_n_o && result_q == $past(result_word_i))
    else $error("update did not raise ready");

  AST_READY_GUARD: assert property (@(posedge clk_i) disable iff (rst_i)
    guard_now |=> result_ready_n_o)
    else $error("ready not high before update");

endmodule

`default_nettype wire

// ==== testbench/srap_host_model.sv ====
`default_nettype none

// ****************************************
// Host side of the three-wire serial link
// ****************************************
module srap_host_model (
  // Serial pins toward the device
  output var  logic sclk_o,
  output var  logic din_o,
  input  wire logic dout_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // Half of the 125 ns serial clock period
  localparam realtime HALF = 62.5;

  // Serial clock idles high and stands still between frames
  initial begin
    sclk_o = 1'b1;
    din_o  = 1'b1;
  end

  // Shifts n bits out and in; the caller picks a command or a data word for each frame,
  // and the factory test register is never touched
  task automatic shift(input int n, input logic [15:0] wd, output logic [15:0] rd);
    rd = 16'h0000;
    // Step off the master clock edges so pin changes never race the sampler
    #1;
    // Data changes on the falling edge, device samples on the rising edge
    for (int i = n - 1; i >= 0; i--) begin
      sclk_o = 1'b0;
      din_o  = wd[i];
      #(HALF);
      rd[i]  = dout_i;
      sclk_o = 1'b1;
      #(HALF);
    end
    // Released data line no longer shows the last bit
    din_o = ~din_o;
  endtask
endmodule

`default_nettype wire

// ==== testbench/serial_register_access_port_tb_top.sv ====
`include "srap_consts.svh"
`default_nettype none

// ****************************************
// Self-checking bench for the serial port
// ****************************************
module serial_register_access_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_i;            // Master clock
  logic        rst_i;            // Synchronous reset
  logic        sclk_i;           // Serial clock from host
  logic        din_i;            // Serial data from host
  logic        dout_o;           // Serial data to host
  logic        result_ready_n_o; // Result ready, active low
  logic [15:0] result_word_i;    // Converter result
  logic        power_down_o;     // Standby state
  logic [1:0]  gain_code_o;      // Gain code
  logic [7:0]  setup_o;          // Setup contents
  logic [7:0]  test_o;           // Test contents
  logic [15:0] rd;               // Last word shifted in by the host
  logic        rdy;              // Ready pin captured before a read
  int          num_errors;       // Mismatch count
  int          samples_checked;  // Comparison count

  // ****************************************
  // Device, host and clock
  // ****************************************
  srap_serial_regs #(.UPDATE_CYCLES(2000)) i_srap_serial_regs (
    .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk_i), .din_i(din_i), .dout_o(dout_o),
    .result_ready_n_o(result_ready_n_o), .result_word_i(result_word_i),
    .power_down_o(power_down_o), .gain_code_o(gain_code_o), .setup_o(setup_o),
    .test_o(test_o));

  srap_host_model i_srap_host_model (.sclk_o(sclk_i), .din_o(din_i), .dout_i(dout_o));

  // 100 MHz master clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ****************************************
  // Helper tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // One host transfer, then time for the device to settle
  task automatic xfer(input int n, input logic [15:0] wd);
    i_srap_host_model.shift(n, wd, rd);
    cyc(10);
  endtask

  // Compares a seen value with the expected one
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      num_errors++;
    end
  endtask

  // Waits a bounded time for the ready pin to go low
  task automatic wait_ready();
    int k;
    k = 0;
    while (result_ready_n_o !== 1'b0 && k < 3000) begin
      cyc(1);
      k++;
    end
  endtask

  task automatic endt(input string name);
    $display("test %s done", name);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(negedge clk_i);
    num_errors++;
    finish_test();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    rst_i = 1'b1;
    result_word_i = 16'hC3A5;
    num_errors = 0;
    samples_checked = 0;
    cyc(10);
    rst_i = 1'b0;
    cyc(5);
    // Reset values
    check(16'(setup_o), 16'(`SRAP_SETUP_RST));
    check(16'(test_o), 16'(`SRAP_TEST_RST));
    check(16'({power_down_o, gain_code_o}), 16'h0000);
    check(16'({dout_o, result_ready_n_o}), 16'h0003);
    endt("reset");
    // Gate ones held, then setup write and read back
    xfer(3, 16'hFFFF);
    xfer(8, 16'h0010);
    xfer(8, 16'h00A5);
    check(16'(setup_o), 16'h00A5);
    xfer(8, 16'h0018);
    xfer(8, 16'h0000);
    check(16'(rd[7:0]), 16'h00A5);
    check(16'(dout_o), 16'h0001);
    // Write to the result register is swallowed
    xfer(8, 16'h0030);
    xfer(16, 16'h5A5A);
    xfer(8, 16'h0018);
    xfer(8, 16'h0000);
    check(16'(rd[7:0]), 16'h00A5);
    endt("setup");
    // Every gain code
    for (int g = 0; g < 4; g++) begin
      xfer(8, 16'h0018 | 16'(g));
      xfer(8, 16'h0000);
      check(16'(gain_code_o), 16'(g));
      check(16'(rd[7:0]), 16'h00A5);
    end
    endt("gain");
    // Ready guard before the next update, unread
    wait_ready();
    cyc(1480);
    check(16'(result_ready_n_o), 16'h0000);
    cyc(40);
    check(16'(result_ready_n_o), 16'h0001);
    // Result read clears ready
    wait_ready();
    check(16'(result_ready_n_o), 16'h0000);
    xfer(8, 16'h0038);
    xfer(16, 16'h0000);
    check(rd, 16'hC3A5);
    check(16'(result_ready_n_o), 16'h0001);
    endt("result");
    // Command read in standby, ready state frozen
    xfer(8, 16'h000F);
    rdy = result_ready_n_o;
    xfer(8, 16'h0000);
    check(16'(rd[7:0]), 16'({rdy, 7'h0F}));
    check(16'(power_down_o), 16'h0001);
    xfer(8, 16'h0018);
    xfer(8, 16'h0000);
    check(16'(power_down_o), 16'h0000);
    // Write to the command register itself updates standby and gain
    xfer(8, 16'h0000);
    xfer(8, 16'h0002);
    check(16'({power_down_o, gain_code_o}), 16'h0002);
    endt("command");
    // Lost framing, then 32 ones restore command wait
    xfer(4, 16'h0001);
    xfer(16, 16'hFFFF);
    xfer(16, 16'hFFFF);
    xfer(8, 16'h0010);
    xfer(8, 16'h005A);
    check(16'(setup_o), 16'h005A);
    endt("resync");
    finish_test();
  end
endmodule

`default_nettype wire
